/* File: ffsr_pkg.sv */
// ffsr_pkg: shared constants and types of the fault record and status register block
// assumes: one 100 MHz clock, byte/word command port from the bus transaction engine
package ffsr_pkg;
  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] FFSR_CMD_STATUS_SUMMARY = 8'h78;
  localparam logic [7:0] FFSR_CMD_FAULT_SNAPSHOT = 8'hd8;
  localparam logic [7:0] FFSR_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] FFSR_CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] FFSR_CMD_TAG_SUPPLIER = 8'h99;
  localparam logic [7:0] FFSR_CMD_TAG_MODEL = 8'h9a;
  localparam logic [7:0] FFSR_CMD_TAG_REVISION = 8'h9b;
  localparam logic [7:0] FFSR_CMD_TAG_DATE = 8'h9d;
  localparam logic [7:0] FFSR_CMD_STATUS_DETAIL = 8'he0;
  localparam logic [7:0] FFSR_PAGE_A = 8'h00;
  localparam logic [7:0] FFSR_PAGE_B = 8'h01;
  localparam logic [7:0] FFSR_PAGE_ALL = 8'hff;
  // ------------------------------------------------------------
  // field positions and values
  // ------------------------------------------------------------
  localparam int FFSR_CODE_A_LSB = 3;
  localparam int FFSR_CODE_B_LSB = 0;
  localparam int FFSR_BIT_OFF = 6;
  localparam int FFSR_BIT_VOUT_OV = 5;
  localparam int FFSR_BIT_IOUT_OC = 4;
  localparam int FFSR_BIT_VIN_UV = 3;
  localparam int FFSR_BIT_TEMP = 2;
  localparam int FFSR_BIT_CML = 1;
  localparam int FFSR_BIT_OTHER = 0;
  localparam logic [2:0] FFSR_CODE_NONE = 3'h0;
  localparam logic [7:0] FFSR_BYTE_ZERO = 8'h00;
  localparam logic [15:0] FFSR_TAG_SUPPLIER_RST = 16'h0001; // arbitrary value
  localparam logic [15:0] FFSR_TAG_MODEL_RST = 16'h0002; // arbitrary value
  localparam logic [15:0] FFSR_TAG_REVISION_RST = 16'h0003; // arbitrary value
  localparam logic [15:0] FFSR_TAG_DATE_RST = 16'h0004; // arbitrary value
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int FFSR_CLK_MHZ = 100;
  localparam int FFSR_STORE_MS = 100;
  localparam int FFSR_STORE_CYCLES = FFSR_STORE_MS * 1000 * FFSR_CLK_MHZ;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FFSR_FC_NONE = 3'h0,
    FFSR_FC_OV_IDLE = 3'h1,
    FFSR_FC_OV_RUN = 3'h2,
    FFSR_FC_IIN_OC = 3'h3,
    FFSR_FC_IOUT_OC = 3'h4,
    FFSR_FC_OT = 3'h5,
    FFSR_FC_STAGE = 3'h6,
    FFSR_FC_PIN_OP = 3'h7
  } ffsr_fault_code_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [7:0] code;
    logic [15:0] data;
  } ffsr_cmd_t;
  // per channel raw events, one cycle or level, from the protection logic
  typedef struct packed {
    logic ov;
    logic iin_oc;
    logic iout_oc;
    logic ot;
    logic stage;
    logic pin_op;
    logic vin_uv;
    logic other;
    logic off;
  } ffsr_chan_evt_t;
  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic vin_uv;
    logic temp;
    logic cml;
    logic other;
  } ffsr_flags_t;
  typedef enum logic [1:0] {
    FFSR_ST_IDLE = 2'b01,
    FFSR_ST_STORE = 2'b10
  } ffsr_state_t;
endpackage

/* File: ffsr_first_fault.sv */
// ffsr_first_fault: one channel of the first fault recorder
// assumes: events synchronous to clk_i, load from the storage shadow after reset
`timescale 1ns/1ps
`default_nettype none
module ffsr_first_fault
  import ffsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic load_i,
  input wire logic [2:0] load_val_i,
  input wire logic clr_i,
  input wire logic converting_i,
  input wire ffsr_chan_evt_t evt_i,
  output logic [2:0] code_o
);
  // ------------------------------------------------------------
  // priority encode of simultaneous events
  // ------------------------------------------------------------
  function automatic logic [2:0] ffsr_encode(input ffsr_chan_evt_t e, input logic run);
    logic [2:0] c;
    c = FFSR_FC_NONE;
    if (e.pin_op) c = FFSR_FC_PIN_OP;
    if (e.stage) c = FFSR_FC_STAGE;
    if (e.ot) c = FFSR_FC_OT;
    if (e.iin_oc) c = FFSR_FC_IIN_OC;
    if (e.iout_oc) c = FFSR_FC_IOUT_OC;
    if (e.ov) c = run ? FFSR_FC_OV_RUN : FFSR_FC_OV_IDLE;
    return c;
  endfunction

  logic [2:0] code_r;
  logic [2:0] hit;
  assign hit = ffsr_encode(evt_i, converting_i);

  // capture is never gated by conversion state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_r <= FFSR_CODE_NONE;
    end else if (en_i) begin
      if (load_i) begin
        code_r <= load_val_i;
      end else if ((code_r == FFSR_CODE_NONE || clr_i) && hit != FFSR_CODE_NONE) begin
        code_r <= hit; // a fault beats a clear in the same cycle
      end else if (clr_i) begin
        code_r <= FFSR_CODE_NONE;
      end
    end
  end
  assign code_o = code_r;
endmodule
`default_nettype wire

/* File: ffsr_flag_bank.sv */
// ffsr_flag_bank: latched summary flags for one channel
// assumes: conditions are same-clock levels or pulses
`timescale 1ns/1ps
`default_nettype none
module ffsr_flag_bank
  import ffsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire ffsr_flags_t set_i,
  input wire ffsr_flags_t clr_i,
  input wire logic clr_all_i,
  output ffsr_flags_t flags_o
);
  ffsr_flags_t flags_r;
  // set wins over any clear so no event is lost
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_r <= '0;
    end else if (en_i) begin
      flags_r <= set_i | (flags_r & ~(clr_i | {6{clr_all_i}}));
    end
  end
  assign flags_o = flags_r;
endmodule
`default_nettype wire

/* File: ffsr_top.sv */
// ffsr_top: fault snapshot, board tags and paged status summary of a dual channel controller
// assumes: a bus transaction engine delivers decoded byte/word commands on cmd_i,
// reads are answered one cycle later on rdata_o with rvalid_o
// Summary of operation
// - snapshot read returns live record; zero means nothing captured since clear
// - snapshot at d8h, byte access only, ignores the page
// - snapshot bits 7:6 read zero and cannot be written
// - channel a code in 5:3, channel b in 2:0, loaded at power-up
// - only the first fault per channel is kept, until cleared
// - non-zero snapshot write ignored, sets the paged channel's communication flag and alert
// - fault code encoding from none through input overpower warning
// - four 16-bit writable tags, reset to default identity values on nrst, not saved by commit
// - status flags latch until clear-all command or write of one
// - status byte is read-only, paged: 00h a, 01h b, ffh a
// - status bit 7 busy always reads zero
// - status bit 6 live, set when channel delivers no power
// - status bit 5 latched output overvoltage
// - status bit 4 latched output overcurrent
// - status bit 3 latched input undervoltage
// - status bit 2 latched overtemperature fault or warning
// - status bit 1 latched communication, memory or logic fault
// - status bit 0 flags any other fault or warning
// - writing ones to detail (e0h) clears the matching summary bits
// - any write to the status byte is an invalid transaction
// - first fault capture active whether or not converting
// - commit writes the fault record to storage, host waits about 100 ms
`timescale 1ns/1ps
`default_nettype none
module ffsr_top
  import ffsr_pkg::*;
#(
  parameter int STORE_CYCLES = FFSR_STORE_CYCLES
)(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic por_i,
  input wire ffsr_cmd_t cmd_i,
  input wire logic [7:0] page_i,
  input wire logic converting_a_i,
  input wire logic converting_b_i,
  input wire ffsr_chan_evt_t evt_a_i,
  input wire ffsr_chan_evt_t evt_b_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic host_alert_output_o,
  output logic store_busy_o,
  output logic [15:0] status_word_cml_o
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic is_cmd(input ffsr_cmd_t c, input logic [7:0] code);
    return c.code == code;
  endfunction
  // next value of a latched bit: set beats clear so no event is lost
  function automatic logic flag_nxt(input logic set, input logic cur, input logic clr);
    return set || (cur && !clr);
  endfunction

  logic chan_b_sel;
  logic wr_snap;
  logic wr_snap_bad;
  logic wr_status_bad;
  logic wr_detail;
  logic clear_all;
  logic store_req;
  logic cml_evt;
  logic [7:0] wsel_mask;
  ffsr_state_t state_r;

  assign chan_b_sel = (page_i == FFSR_PAGE_B); // 00h and ffh both select a
  assign wr_snap = cmd_i.wr && !cmd_i.word && is_cmd(cmd_i, FFSR_CMD_FAULT_SNAPSHOT);
  assign wr_snap_bad = wr_snap && (cmd_i.data[7:0] != FFSR_BYTE_ZERO);
  // word access to the byte-only register is also refused
  assign wr_status_bad = cmd_i.wr && is_cmd(cmd_i, FFSR_CMD_STATUS_SUMMARY);
  assign wr_detail = cmd_i.wr && is_cmd(cmd_i, FFSR_CMD_STATUS_DETAIL);
  assign clear_all = cmd_i.wr && is_cmd(cmd_i, FFSR_CMD_CLEAR_FAULTS);
  assign store_req = cmd_i.wr && is_cmd(cmd_i, FFSR_CMD_STORE_ALL) && (state_r == FFSR_ST_IDLE);
  assign cml_evt = wr_snap_bad || wr_status_bad
    || (cmd_i.wr && cmd_i.word && is_cmd(cmd_i, FFSR_CMD_FAULT_SNAPSHOT));
  assign wsel_mask = cmd_i.data[7:0];

  // ------------------------------------------------------------
  // power-up reload and storage commit
  // ------------------------------------------------------------
  logic [31:0] store_cnt_r;
  logic [5:0] shadow_r;
  logic load_r;
  logic por_s1_r;
  logic por_s2_r;

  // por is a pin: two stages before use
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_s1_r <= 1'b1;
      por_s2_r <= 1'b1;
    end else if (en_i) begin
      por_s1_r <= por_i;
      por_s2_r <= por_s1_r;
    end
  end

  // reload after every reset release and on power-up strobe
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_r <= 1'b1;
    end else if (en_i) begin
      load_r <= por_s2_r;
    end
  end

  // shadow models the storage array: survives nrst and por, only a commit writes it
  logic [5:0] live_codes;
  always_ff @(posedge clk_i) begin
    if (en_i && store_req) begin
      shadow_r <= live_codes;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= FFSR_ST_IDLE;
      store_cnt_r <= '0;
    end else if (en_i) begin
      unique case (state_r)
        FFSR_ST_IDLE: begin
          if (store_req) begin
            state_r <= FFSR_ST_STORE;
            store_cnt_r <= 32'(STORE_CYCLES - 1);
          end
        end
        FFSR_ST_STORE: begin
          if (store_cnt_r == '0) begin
            state_r <= FFSR_ST_IDLE;
          end else begin
            store_cnt_r <= store_cnt_r - 32'h0000_0001;
          end
        end
        default: state_r <= FFSR_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // first fault recorders
  // ------------------------------------------------------------
  logic [2:0] code_a;
  logic [2:0] code_b;
  logic snap_clr;
  // a zero write clears both fields; non-zero is dropped whole
  assign snap_clr = wr_snap && !wr_snap_bad;

  ffsr_first_fault u_rec_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .load_i(load_r),
    .load_val_i(shadow_r[5:3]),
    .clr_i(snap_clr),
    .converting_i(converting_a_i),
    .evt_i(evt_a_i),
    .code_o(code_a)
  );
  ffsr_first_fault u_rec_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .load_i(load_r),
    .load_val_i(shadow_r[2:0]),
    .clr_i(snap_clr),
    .converting_i(converting_b_i),
    .evt_i(evt_b_i),
    .code_o(code_b)
  );
  assign live_codes = {code_a, code_b};

  // ------------------------------------------------------------
  // board tags
  // ------------------------------------------------------------
  logic [15:0] tag_r [4];
  logic [1:0] tag_idx;
  logic tag_hit;
  always_comb begin
    tag_idx = 2'd0;
    tag_hit = 1'b1;
    unique case (cmd_i.code)
      FFSR_CMD_TAG_SUPPLIER: tag_idx = 2'd0;
      FFSR_CMD_TAG_MODEL: tag_idx = 2'd1;
      FFSR_CMD_TAG_REVISION: tag_idx = 2'd2;
      FFSR_CMD_TAG_DATE: tag_idx = 2'd3;
      default: tag_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tag_r[0] <= FFSR_TAG_SUPPLIER_RST;
      tag_r[1] <= FFSR_TAG_MODEL_RST;
      tag_r[2] <= FFSR_TAG_REVISION_RST;
      tag_r[3] <= FFSR_TAG_DATE_RST;
    end else if (en_i && cmd_i.wr && cmd_i.word && tag_hit) begin
      tag_r[tag_idx] <= cmd_i.data;
    end
  end

  // ------------------------------------------------------------
  // summary flags
  // ------------------------------------------------------------
  ffsr_flags_t set_a;
  ffsr_flags_t set_b;
  ffsr_flags_t clr_a;
  ffsr_flags_t clr_b;
  ffsr_flags_t flags_a;
  ffsr_flags_t flags_b;
  function automatic ffsr_flags_t to_flags(input ffsr_chan_evt_t e, input logic cml);
    ffsr_flags_t f;
    f.vout_ov = e.ov;
    f.iout_oc = e.iout_oc;
    f.vin_uv = e.vin_uv;
    f.temp = e.ot;
    f.cml = cml;
    f.other = e.other || e.iin_oc || e.stage || e.pin_op;
    return f;
  endfunction
  // communication fault lands on the page that was addressed
  assign set_a = to_flags(evt_a_i, cml_evt && !chan_b_sel);
  assign set_b = to_flags(evt_b_i, cml_evt && chan_b_sel);
  // detail write: ones clear the matching summary bits on the paged channel
  assign clr_a = (wr_detail && !chan_b_sel) ? ffsr_flags_t'(wsel_mask[5:0]) : '0;
  assign clr_b = (wr_detail && chan_b_sel) ? ffsr_flags_t'(wsel_mask[5:0]) : '0;

  ffsr_flag_bank u_flags_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .set_i(set_a),
    .clr_i(clr_a),
    .clr_all_i(clear_all),
    .flags_o(flags_a)
  );
  ffsr_flag_bank u_flags_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .set_i(set_b),
    .clr_i(clr_b),
    .clr_all_i(clear_all),
    .flags_o(flags_b)
  );

  // ------------------------------------------------------------
  // read path and outputs
  // ------------------------------------------------------------
  function automatic logic [7:0] status_byte(input ffsr_flags_t f, input logic off);
    logic [7:0] b;
    b = FFSR_BYTE_ZERO; // busy bit stays zero
    b[FFSR_BIT_OFF] = off; // live, not latched
    b[FFSR_BIT_VOUT_OV] = f.vout_ov;
    b[FFSR_BIT_IOUT_OC] = f.iout_oc;
    b[FFSR_BIT_VIN_UV] = f.vin_uv;
    b[FFSR_BIT_TEMP] = f.temp;
    b[FFSR_BIT_CML] = f.cml;
    b[FFSR_BIT_OTHER] = f.other;
    return b;
  endfunction

  logic [15:0] rd_nxt;
  always_comb begin
    rd_nxt = '0;
    if (is_cmd(cmd_i, FFSR_CMD_FAULT_SNAPSHOT) && !cmd_i.word) begin
      rd_nxt = {8'h00, 2'b00, code_a, code_b};
    end else if (is_cmd(cmd_i, FFSR_CMD_STATUS_SUMMARY) && !cmd_i.word) begin
      rd_nxt = {8'h00, chan_b_sel ? status_byte(flags_b, evt_b_i.off)
                                  : status_byte(flags_a, evt_a_i.off)};
    end else if (tag_hit && cmd_i.word) begin
      rd_nxt = tag_r[tag_idx];
    end
  end

  logic alert_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
      rvalid_o <= 1'b0;
    end else if (en_i) begin
      rvalid_o <= cmd_i.rd;
      if (cmd_i.rd) begin
        rdata_o <= rd_nxt;
      end
    end
  end

  // alert held until clear-all; a new invalid write wins over the clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alert_r <= 1'b0;
    end else if (en_i) begin
      alert_r <= flag_nxt(cml_evt, alert_r, clear_all);
    end
  end
  assign host_alert_output_o = alert_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      store_busy_o <= 1'b0;
      status_word_cml_o <= '0;
    end else if (en_i) begin
      store_busy_o <= store_req || (state_r == FFSR_ST_STORE && store_cnt_r != '0);
      // built from next flag values so the word changes with the flag bank, not a cycle late
      status_word_cml_o <= {14'h0000,
                            flag_nxt(set_b.cml, flags_b.cml, clr_b.cml || clear_all),
                            flag_nxt(set_a.cml, flags_a.cml, clr_a.cml || clear_all)};
    end
  end
endmodule
`default_nettype wire

/* File: ffsr_chk.sv */
// ffsr_chk: port-level checks of the fault record and status register block
// assumes: bound to ffsr_top, one clock, en_i held high by the bench except in one frozen-enable step
`timescale 1ns/1ps
`default_nettype none
module ffsr_chk
  import ffsr_pkg::*;
#(
  parameter int STORE_CYCLES = 8
)(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire ffsr_cmd_t cmd_i,
  input wire logic [7:0] page_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic host_alert_output_o,
  input wire logic store_busy_o,
  input wire logic [15:0] status_word_cml_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ------------------------------------------------------------
  // commit length counter
  // ------------------------------------------------------------
  logic [31:0] busy_cnt_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= store_busy_o ? busy_cnt_r + 32'h0000_0001 : '0;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  read_answer_a: assert property (en_i && cmd_i.rd |=> rvalid_o)
    else $error("read not answered next cycle");
  no_spur_valid_a: assert property (rvalid_o |-> $past(en_i && cmd_i.rd))
    else $error("read data valid without a read");
  snap_top_zero_a: assert property (rvalid_o && $past(cmd_i.code == FFSR_CMD_FAULT_SNAPSHOT)
    |-> rdata_o[7:6] == 2'b00) else $error("snapshot top bits not zero");
  busy_zero_a: assert property (rvalid_o && $past(cmd_i.code == FFSR_CMD_STATUS_SUMMARY)
    |-> !rdata_o[7]) else $error("status busy bit set");
  bad_snap_alert_a: assert property (en_i && cmd_i.wr && cmd_i.code == FFSR_CMD_FAULT_SNAPSHOT
    && cmd_i.data[7:0] != 8'h00 |=> host_alert_output_o
    && status_word_cml_o[($past(page_i) == FFSR_PAGE_B) ? 1 : 0]) else $error("bad write no alert");
  stat_write_alert_a: assert property (en_i && cmd_i.wr
    && cmd_i.code == FFSR_CMD_STATUS_SUMMARY |=> host_alert_output_o)
    else $error("status write not refused");
  alert_hold_a: assert property (host_alert_output_o
    && !(en_i && cmd_i.wr && cmd_i.code == FFSR_CMD_CLEAR_FAULTS) |=> host_alert_output_o)
    else $error("alert dropped without clear");
  clear_alert_a: assert property (en_i && cmd_i.wr && cmd_i.code == FFSR_CMD_CLEAR_FAULTS
    |=> !host_alert_output_o && status_word_cml_o[1:0] == 2'b00) else $error("clear left flags");
  commit_busy_a: assert property (en_i && cmd_i.wr && cmd_i.code == FFSR_CMD_STORE_ALL
    && !store_busy_o |=> store_busy_o) else $error("commit did not start");
  commit_len_a: assert property (busy_cnt_r <= STORE_CYCLES)
    else $error("commit runs too long");
endmodule
`default_nettype wire

/* File: ffsr_host.sv */
// ffsr_host: bus host model issuing one decoded command per call
// assumes: commands launched just after a rising edge, held one cycle
`timescale 1ns/1ps
`default_nettype none
module ffsr_host
  import ffsr_pkg::*;
(
  input wire logic clk_i,
  output var ffsr_cmd_t cmd_o
);
  initial cmd_o = '0;
  // idle gap after every command: a slow host, never a burst
  task automatic xfer(input logic wr, input logic rd, input logic word,
                      input logic [7:0] code, input logic [15:0] data);
    @(posedge clk_i);
    cmd_o <= {wr, rd, word, code, data};
    @(posedge clk_i);
    cmd_o <= '0;
  endtask
  // zero write wipes the live record; commit must follow to wipe storage
  task automatic clear_record();
    xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_FAULT_SNAPSHOT, 16'h0000);
  endtask
  task automatic commit();
    xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_STORE_ALL, 16'h0000);
  endtask
endmodule
`default_nettype wire

/* File: test_fault_record_status_regs.sv */
// test_fault_record_status_regs: self-checking bench of the register block
// assumes: ffsr_host drives commands, short commit count in simulation
`timescale 1ns/1ps
`default_nettype none
module test_fault_record_status_regs;
  import ffsr_pkg::*;
  localparam int STORE_CYCLES = 8;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic por_i = 1'b0;
  logic en = 1'b1;
  logic conv_a = 1'b0;
  logic conv_b = 1'b1;
  logic [7:0] page_i = FFSR_PAGE_A;
  ffsr_chan_evt_t evt_a = 9'h001;
  ffsr_chan_evt_t evt_b = 9'h000;
  ffsr_cmd_t cmd;
  logic [15:0] rdata, cml, e_v, m_v;
  logic rvalid, alert, busy;
  int miscompares = 0;
  int total_checks = 0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [31:0] seed = 32'h5ae7_0756;
  logic [7:0] tag_code[4] = '{FFSR_CMD_TAG_SUPPLIER, FFSR_CMD_TAG_MODEL,
                              FFSR_CMD_TAG_REVISION, FFSR_CMD_TAG_DATE};
  logic [15:0] tag_rst[4] = '{FFSR_TAG_SUPPLIER_RST, FFSR_TAG_MODEL_RST,
                              FFSR_TAG_REVISION_RST, FFSR_TAG_DATE_RST};
  int fbit[8] = '{0, 8, 8, 7, 6, 5, 4, 3};
  int sev[5] = '{8, 6, 2, 5, 1};
  int sbit[5] = '{5, 4, 3, 2, 0};
  int i;
  always #5 clk_i = ~clk_i;
  ffsr_top #(.STORE_CYCLES(STORE_CYCLES)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .por_i(por_i), .cmd_i(cmd),
    .page_i(page_i), .converting_a_i(conv_a), .converting_b_i(conv_b),
    .evt_a_i(evt_a), .evt_b_i(evt_b), .rdata_o(rdata), .rvalid_o(rvalid),
    .host_alert_output_o(alert), .store_busy_o(busy), .status_word_cml_o(cml));
  ffsr_host u_host (.clk_i(clk_i), .cmd_o(cmd));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] code, input logic word, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_host.xfer(1'b0, 1'b1, word, code, 16'h0000);
  endtask
  // one-cycle fault pulse; off level in bit 0 left alone
  task automatic hit(input logic chan_b, input int bitn);
    @(posedge clk_i);
    if (chan_b) evt_b[bitn] <= 1'b1;
    else evt_a[bitn] <= 1'b1;
    @(posedge clk_i);
    evt_a[8:1] <= 8'h00;
    evt_b[8:1] <= 8'h00;
  endtask
  task automatic wait_store();
    int n;
    n = 0;
    @(posedge clk_i);
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      $display("MISMATCH %0t commit never finished", $time);
      print_verdict();
    end
  endtask
  // ------------------------------------------------------------
  // read monitor: oldest note against each answer
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("MISMATCH %0t unexpected read answer", $time);
      end else begin
        e_v = exp_q.pop_front();
        m_v = msk_q.pop_front();
        if ((rdata & m_v) !== e_v) begin
          miscompares++;
          $display("MISMATCH %0t read %h expected %h", $time, rdata & m_v, e_v);
        end
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("MISMATCH %0t run timed out", $time);
    print_verdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    u_host.clear_record();
    rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'h0000, 16'h00ff);
    for (i = 0; i < 4; i++) rd(tag_code[i], 1'b1, tag_rst[i], 16'hffff);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      u_host.xfer(1'b1, 1'b0, 1'b1, tag_code[i], seed[15:0]);
      rd(tag_code[i], 1'b1, seed[15:0], 16'hffff);
    end
    // every code; a second fault must leave the first in place
    for (i = 1; i < 8; i++) begin
      u_host.clear_record();
      conv_a <= (i == 2);
      hit(1'b0, fbit[i]);
      hit(1'b0, (i == 3) ? 6 : 7);
      rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'(i * 8), 16'h00ff);
    end
    hit(1'b1, 4);
    rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'h003e, 16'h00ff);
    u_host.commit();
    wait_store();
    u_host.clear_record();
    rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'h0000, 16'h00ff);
    @(posedge clk_i);
    por_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    por_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'h003e, 16'h00ff);
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'h003e, 16'h00ff);
    seed = xs(seed);
    u_host.xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_FAULT_SNAPSHOT, {8'h00, seed[7:0] | 8'h01});
    rd(FFSR_CMD_FAULT_SNAPSHOT, 1'b0, 16'h003e, 16'h00ff);
    total_checks++;
    if (alert !== 1'b1 || cml !== 16'h0001) begin
      miscompares++;
      $display("MISMATCH %0t no alert or flag after bad write", $time);
    end
    rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'h0002, 16'h0002);
    u_host.xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_CLEAR_FAULTS, 16'h0000);
    rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'h0040, 16'h00ff);
    total_checks++;
    if (alert !== 1'b0 || cml !== 16'h0000) begin
      miscompares++;
      $display("MISMATCH %0t alert or flag left after clear", $time);
    end
    page_i <= FFSR_PAGE_B;
    u_host.xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_STATUS_SUMMARY, 16'h0000);
    rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'h0002, 16'h00ff);
    page_i <= FFSR_PAGE_ALL;
    rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'h0040, 16'h00ff);
    u_host.xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_CLEAR_FAULTS, 16'h0000);
    page_i <= FFSR_PAGE_B;
    // frozen clock enable: a fault pulse must not latch
    en <= 1'b0;
    hit(1'b1, 8);
    en <= 1'b1;
    rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'h0000, 16'h00ff);
    for (i = 0; i < 5; i++) begin
      hit(1'b1, sev[i]);
      rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'(1 << sbit[i]), 16'h00ff);
      u_host.xfer(1'b1, 1'b0, 1'b0, FFSR_CMD_STATUS_DETAIL, 16'(1 << sbit[i]));
      rd(FFSR_CMD_STATUS_SUMMARY, 1'b0, 16'h0000, 16'h00ff);
    end
    repeat (4) @(posedge clk_i);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("MISMATCH %0t reads left unanswered", $time);
    end
    print_verdict();
  end
endmodule
bind ffsr_top ffsr_chk #(.STORE_CYCLES(STORE_CYCLES)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .cmd_i(cmd_i), .page_i(page_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .host_alert_output_o(host_alert_output_o),
  .store_busy_o(store_busy_o), .status_word_cml_o(status_word_cml_o));
`default_nettype wire
